// *** hdl/tat_top.v ***
// Translation lookaside buffer with its control registers
`timescale 1ns/1ps
`include "tat_regs.vh"
module tat_top
#(
   parameter WAYS = 4,
   parameter SETS = 32
)
(
   input wire clk,
   input wire reset_n,
   input wire req_valid,
   input wire [31:0] req_vaddr,
   input wire req_write,
   input wire req_priv,
   input wire load_entry_op,
   input wire reg_rd,
   input wire reg_wr,
   input wire reg_priv,
   input wire [31:0] reg_addr,
   input wire [31:0] reg_wdata,
   output reg resp_valid,
   output reg [31:0] resp_paddr,
   output reg resp_go,
   output reg resp_cacheable,
   output reg exc_miss,
   output reg exc_prot,
   output reg exc_init_write,
   output reg exc_addr_err,
   output reg [31:0] reg_rdata,
   output reg reg_refused
);
   localparam ENTRIES = WAYS * SETS;

   reg rst_s1;
   reg rst_s2;
   wire rst_n;

   // Control and staging registers
   reg ctl_enable;
   reg ctl_hash;
   reg ctl_single;
   reg [1:0] repl_way;
   reg [21:0] peh_page;
   reg [7:0] peh_id;
   reg [31:0] page_entry_low;
   reg [31:0] table_base;
   reg [31:0] fault_address;

   // Entry storage; only the valid bits are control state and get a reset
   reg [ENTRIES-1:0] ent_valid;
   reg [21:0] ent_page [0:ENTRIES-1];
   reg [7:0] ent_id [0:ENTRIES-1];
   reg [18:0] ent_frame [0:ENTRIES-1];
   reg [1:0] ent_rights [0:ENTRIES-1];
   reg ent_big [0:ENTRIES-1];
   reg ent_cache [0:ENTRIES-1];
   reg ent_dirty [0:ENTRIES-1];
   reg ent_shared [0:ENTRIES-1];

   function [4:0] tat_index;
      input [4:0] page_bits;
      input [4:0] id_bits;
      input hash;
      begin
         tat_index = hash ? (page_bits ^ id_bits) : page_bits;
      end
   endfunction

   function tat_rights_ok;
      input [1:0] rights;
      input priv;
      input write;
      begin
         case (rights)
            `TAT_RIGHTS_PRIV_RO: tat_rights_ok = priv & ~write;
            `TAT_RIGHTS_PRIV_RW: tat_rights_ok = priv;
            `TAT_RIGHTS_ALL_RO: tat_rights_ok = ~write;
            default: tat_rights_ok = 1'b1;
         endcase
      end
   endfunction

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end
   assign rst_n = rst_s2;

   // Lookup path
   wire [4:0] set_idx;
   wire [4:0] load_idx;
   wire skip_id;
   wire [WAYS-1:0] way_hit;
   wire [WAYS-1:0] way_valid;
   assign set_idx = tat_index(req_vaddr[16:12], peh_id[4:0], ctl_hash);
   assign load_idx = tat_index(peh_page[6:2], peh_id[4:0], ctl_hash);
   assign skip_id = ctl_single & req_priv;

   genvar w;
   generate
      for (w = 0; w < WAYS; w = w + 1)
      begin : g_way
         // Way number as a sized constant; a select on the loop variable is not portable
         localparam [1:0] WAY_NUM = w;
         wire [6:0] slot;
         assign slot = {WAY_NUM, set_idx};
         assign way_valid[w] = ent_valid[slot];
         tat_way_match u_match
         (
            .ent_valid(ent_valid[slot]),
            .ent_page(ent_page[slot]),
            .ent_id(ent_id[slot]),
            .ent_big(ent_big[slot]),
            .ent_shared(ent_shared[slot]),
            .look_page(req_vaddr[31:10]),
            .cur_id(peh_id),
            .skip_id(skip_id),
            .hit(way_hit[w])
         );
      end
   endgenerate

   // Several hits are a software fault; lowest way is taken then
   reg [1:0] hit_way;
   reg [1:0] free_way;
   integer k;
   always @*
   begin
      hit_way = 2'h0;
      free_way = 2'h0;
      for (k = WAYS - 1; k >= 0; k = k - 1)
      begin
         if (way_hit[k])
            hit_way = k[1:0];
         if (!way_valid[k])
            free_way = k[1:0];
      end
   end

   wire [6:0] hit_slot;
   wire hit_any;
   wire hit_big;
   wire [18:0] hit_frame;
   wire [31:0] hit_paddr;
   assign hit_slot = {hit_way, set_idx};
   assign hit_any = |way_hit;
   assign hit_big = ent_big[hit_slot];
   assign hit_frame = ent_frame[hit_slot];
   assign hit_paddr = hit_big ? {3'h0, hit_frame[18:2], req_vaddr[11:0]} : {3'h0, hit_frame, req_vaddr[9:0]};

   // Region decode: user may only reach the lower half; fixed regions bypass the buffer
   wire user_bad;
   wire fixed_region;
   wire translated;
   wire fixed_cache;
   assign user_bad = ~req_priv & req_vaddr[31];
   assign fixed_region = req_vaddr[31] & (req_vaddr[31:29] != 3'h6);
   assign translated = ctl_enable & ~fixed_region;
   assign fixed_cache = (req_vaddr[31:29] != 3'h5) & (req_vaddr[31:29] != 3'h7);

   wire rights_ok;
   wire clean_write;
   assign rights_ok = tat_rights_ok(ent_rights[hit_slot], req_priv, req_write);
   assign clean_write = req_write & ~ent_dirty[hit_slot];

   reg next_miss;
   reg next_prot;
   reg next_init;
   always @*
   begin
      next_miss = 1'b0;
      next_prot = 1'b0;
      next_init = 1'b0;
      if (req_valid && !user_bad && translated)
      begin
         if (!hit_any)
            next_miss = 1'b1;
         else if (!rights_ok)
            next_prot = 1'b1;
         else if (clean_write)
            next_init = 1'b1;
      end
   end

   wire fault;
   assign fault = req_valid & (user_bad | next_miss | next_prot | next_init);

   // Register port decode
   wire acc_ok;
   wire sel_peh;
   wire sel_pel;
   wire sel_base;
   wire sel_fault;
   wire sel_ctrl;
   wire wr_ok;
   assign acc_ok = reg_priv;
   assign sel_peh = (reg_addr == `TAT_ADDR_PEH);
   assign sel_pel = (reg_addr == `TAT_ADDR_PEL);
   assign sel_base = (reg_addr == `TAT_ADDR_BASE);
   assign sel_fault = (reg_addr == `TAT_ADDR_FAULT);
   assign sel_ctrl = (reg_addr == `TAT_ADDR_CTRL);
   assign wr_ok = reg_wr & acc_ok;

   reg [31:0] ctrl_word;
   reg [31:0] read_word;
   always @*
   begin
      ctrl_word = 32'h00000000;
      ctrl_word[`TAT_CTRL_ENABLE] = ctl_enable;
      ctrl_word[`TAT_CTRL_HASH] = ctl_hash;
      ctrl_word[`TAT_CTRL_SINGLE] = ctl_single;
      ctrl_word[`TAT_CTRL_WAY_HI:`TAT_CTRL_WAY_LO] = repl_way;
      read_word = 32'h00000000;
      if (sel_peh)
         read_word = {peh_page, 2'h0, peh_id};
      else if (sel_pel)
         read_word = page_entry_low;
      else if (sel_base)
         read_word = table_base;
      else if (sel_fault)
         read_word = fault_address;
      else if (sel_ctrl)
         read_word = ctrl_word;
   end

   // Registers and responses; a hardware capture beats a software write in the same cycle
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl_enable <= 1'b0;
         ctl_hash <= 1'b0;
         ctl_single <= 1'b0;
         repl_way <= 2'h0;
         peh_page <= 22'h000000;
         peh_id <= 8'h00;
         page_entry_low <= 32'h00000000;
         table_base <= 32'h00000000;
         fault_address <= 32'h00000000;
         resp_valid <= 1'b0;
         resp_paddr <= 32'h00000000;
         resp_go <= 1'b0;
         resp_cacheable <= 1'b0;
         exc_miss <= 1'b0;
         exc_prot <= 1'b0;
         exc_init_write <= 1'b0;
         exc_addr_err <= 1'b0;
         reg_rdata <= 32'h00000000;
         reg_refused <= 1'b0;
      end
      else
      begin
         reg_refused <= (reg_rd | reg_wr) & ~acc_ok;
         if (reg_rd && acc_ok)
            reg_rdata <= read_word;
         if (wr_ok && sel_peh)
         begin
            peh_page <= reg_wdata[`TAT_PEH_PAGE_HI:`TAT_PEH_PAGE_LO];
            peh_id <= reg_wdata[`TAT_PEH_ID_HI:`TAT_PEH_ID_LO];
         end
         if (wr_ok && sel_pel)
            page_entry_low <= reg_wdata;
         if (wr_ok && sel_base)
            table_base <= reg_wdata;
         if (wr_ok && sel_fault)
            fault_address <= reg_wdata;
         if (wr_ok && sel_ctrl)
         begin
            ctl_enable <= reg_wdata[`TAT_CTRL_ENABLE];
            ctl_hash <= reg_wdata[`TAT_CTRL_HASH];
            ctl_single <= reg_wdata[`TAT_CTRL_SINGLE];
            repl_way <= reg_wdata[`TAT_CTRL_WAY_HI:`TAT_CTRL_WAY_LO];
         end
         resp_valid <= req_valid;
         resp_go <= req_valid & ~fault;
         exc_miss <= next_miss;
         exc_prot <= next_prot;
         exc_init_write <= next_init;
         exc_addr_err <= req_valid & user_bad;
         if (req_valid)
         begin
            if (translated)
            begin
               resp_paddr <= hit_paddr;
               resp_cacheable <= ent_cache[hit_slot];
            end
            else
            begin
               resp_paddr <= {3'h0, req_vaddr[28:0]};
               resp_cacheable <= fixed_cache;
            end
         end
         if (fault)
         begin
            peh_page <= req_vaddr[31:10];
            fault_address <= req_vaddr;
         end
         if (next_miss)
         begin
            if (&way_valid)
               repl_way <= repl_way + 2'h1;
            else
               repl_way <= free_way;
         end
      end
   end

   // Entry storage; flush clears every valid bit, a load in the same cycle survives it
   wire [6:0] load_slot;
   assign load_slot = {repl_way, load_idx};
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ent_valid <= {ENTRIES{1'b0}};
      else
      begin
         if (wr_ok && sel_ctrl && reg_wdata[`TAT_CTRL_FLUSH])
            ent_valid <= {ENTRIES{1'b0}};
         if (load_entry_op)
            ent_valid[load_slot] <= page_entry_low[`TAT_PEL_VALID];
      end
   end

   always @(posedge clk)
   begin
      if (load_entry_op)
      begin
         ent_page[load_slot] <= peh_page;
         ent_id[load_slot] <= peh_id;
         ent_frame[load_slot] <= page_entry_low[`TAT_PEL_FRAME_HI:`TAT_PEL_FRAME_LO];
         ent_rights[load_slot] <= page_entry_low[`TAT_PEL_RIGHTS_HI:`TAT_PEL_RIGHTS_LO];
         ent_big[load_slot] <= page_entry_low[`TAT_PEL_BIG];
         ent_cache[load_slot] <= page_entry_low[`TAT_PEL_CACHE];
         ent_dirty[load_slot] <= page_entry_low[`TAT_PEL_DIRTY];
         ent_shared[load_slot] <= page_entry_low[`TAT_PEL_SHARED];
      end
   end
endmodule

// *** hdl/tat_regs.vh ***
// Register offsets, field positions and reset values of the address-translation unit
`ifndef TAT_REGS_VH
`define TAT_REGS_VH
`define TAT_ADDR_PEH 32'hFFFFFFF0
`define TAT_ADDR_PEL 32'hFFFFFFF4
`define TAT_ADDR_BASE 32'h0FFFFFF8
`define TAT_ADDR_FAULT 32'h0FFFFFFC
`define TAT_ADDR_CTRL 32'h0FFFFFF0
`define TAT_CTRL_ENABLE 0
`define TAT_CTRL_FLUSH 2
`define TAT_CTRL_HASH 5
`define TAT_CTRL_WAY_LO 6
`define TAT_CTRL_WAY_HI 7
`define TAT_CTRL_SINGLE 8
`define TAT_CTRL_RESET 32'h00000000
`define TAT_PEH_PAGE_HI 31
`define TAT_PEH_PAGE_LO 10
`define TAT_PEH_ID_HI 7
`define TAT_PEH_ID_LO 0
`define TAT_PEL_FRAME_HI 28
`define TAT_PEL_FRAME_LO 10
`define TAT_PEL_VALID 8
`define TAT_PEL_RIGHTS_HI 6
`define TAT_PEL_RIGHTS_LO 5
`define TAT_PEL_BIG 4
`define TAT_PEL_CACHE 3
`define TAT_PEL_DIRTY 2
`define TAT_PEL_SHARED 1
`define TAT_RIGHTS_PRIV_RO 2'h0
`define TAT_RIGHTS_PRIV_RW 2'h1
`define TAT_RIGHTS_ALL_RO 2'h2
`define TAT_RIGHTS_ALL_RW 2'h3
`endif

// *** hdl/tat_way_match.v ***
// Tag comparison of one translation way
`timescale 1ns/1ps
module tat_way_match
(
   input wire ent_valid,
   input wire [21:0] ent_page,
   input wire [7:0] ent_id,
   input wire ent_big,
   input wire ent_shared,
   input wire [21:0] look_page,
   input wire [7:0] cur_id,
   input wire skip_id,
   output wire hit
);
   wire upper_eq;
   wire low_eq;
   wire id_eq;
   assign upper_eq = (ent_page[21:2] == look_page[21:2]);
   // Low two page bits only matter for small pages
   assign low_eq = ent_big | (ent_page[1:0] == look_page[1:0]);
   assign id_eq = ent_shared | skip_id | (ent_id == cur_id);
   assign hit = ent_valid & upper_eq & low_eq & id_eq;
endmodule

// *** tb/tat_checker_assertions.sv ***
// Port-level concurrent checks for the translation unit
`timescale 1ns/1ps
module tat_checker
(
   input wire clk,
   input wire reset_n,
   input wire req_valid,
   input wire [31:0] req_vaddr,
   input wire req_write,
   input wire req_priv,
   input wire reg_rd,
   input wire reg_wr,
   input wire reg_priv,
   input wire resp_valid,
   input wire [31:0] resp_paddr,
   input wire resp_go,
   input wire exc_miss,
   input wire exc_prot,
   input wire exc_init_write,
   input wire exc_addr_err,
   input wire reg_refused
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   wire any_exc = exc_miss | exc_prot | exc_init_write | exc_addr_err;

   resp_follow_a: assert property (req_valid |=> resp_valid) else $error("no response");
   resp_cause_a: assert property (resp_valid |-> $past(req_valid)) else $error("stray response");
   go_clean_a: assert property (resp_go |-> resp_valid && !any_exc) else $error("go with fault");
   miss_blocks_a: assert property (exc_miss |-> !resp_go && !exc_prot) else $error("miss let through");
   refuse_pulse_a: assert property ((reg_rd || reg_wr) && !reg_priv |=> reg_refused) else $error("not refused");
   refuse_cause_a: assert property (reg_refused |-> $past((reg_rd || reg_wr) && !reg_priv)) else $error("bad refuse");
   first_write_a: assert property (exc_init_write |-> $past(req_write) && !exc_prot) else $error("bad first write");
   user_high_a: assert property (req_valid && !req_priv && req_vaddr[31] |=> exc_addr_err) else $error("no addr error");
   paddr_top_a: assert property (resp_go |-> resp_paddr[31:29] == 3'h0) else $error("paddr top set");
endmodule

bind tat_top tat_checker u_tat_checker (.clk, .reset_n, .req_valid, .req_vaddr, .req_write, .req_priv,
   .reg_rd, .reg_wr, .reg_priv, .resp_valid, .resp_paddr, .resp_go, .exc_miss, .exc_prot, .exc_init_write,
   .exc_addr_err, .reg_refused);

// *** tb/tat_core_model.sv ***
// Core-side model that issues one translation request at a time
`timescale 1ns/1ps
module tat_core_model
(
   input wire clk,
   output reg req_valid,
   output reg [31:0] req_vaddr,
   output reg req_write,
   output reg req_priv
);
   initial
   begin
      req_valid = 1'b0;
      req_vaddr = 32'h0;
      req_write = 1'b0;
      req_priv = 1'b0;
   end
   // Only issued when the caller asks, never beside a control write
   task issue(input [31:0] va, input w, input p);
      @(posedge clk);
      req_valid <= 1'b1;
      req_vaddr <= va;
      req_write <= w;
      req_priv <= p;
      @(posedge clk);
      req_valid <= 1'b0;
      // Released address and write lines flip so stale values cannot pass
      req_vaddr <= ~va;
      req_write <= ~w;
   endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the translation unit
`timescale 1ns/1ps
`include "tat_regs.vh"
module testbench;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic load_entry_op = 1'b0;
   logic reg_rd = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_priv = 1'b0;
   logic [31:0] reg_addr = 32'h0;
   logic [31:0] reg_wdata = 32'h0;
   wire req_valid, req_write, req_priv, resp_valid, resp_go, resp_cacheable, reg_refused;
   wire exc_miss, exc_prot, exc_init_write, exc_addr_err;
   wire [31:0] req_vaddr, resp_paddr, reg_rdata;
   int fails = 0;
   int n_tests = 0;
   int f;
   logic [31:0] va, pel, r, d, pa;
   logic [18:0] frame;
   logic [7:0] id;
   logic big, shared, hash;
   logic [31:0] rmap [5] = '{`TAT_ADDR_PEH, `TAT_ADDR_PEL, `TAT_ADDR_BASE, `TAT_ADDR_FAULT, `TAT_ADDR_CTRL};

   always #5 clk = ~clk;

   tat_core_model u_tat_core_model (.clk, .req_valid, .req_vaddr, .req_write, .req_priv);
   tat_top u_tat_top (.clk, .reset_n, .req_valid, .req_vaddr, .req_write, .req_priv, .load_entry_op,
      .reg_rd, .reg_wr, .reg_priv, .reg_addr, .reg_wdata, .resp_valid, .resp_paddr, .resp_go,
      .resp_cacheable, .exc_miss, .exc_prot, .exc_init_write, .exc_addr_err, .reg_rdata, .reg_refused);

   task check(input string what, input [31:0] seen, input [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task print_verdict;
      if (fails == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task wr(input [31:0] a, input [31:0] v, input p);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      reg_priv <= p;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~v;
   endtask

   task rd(input [31:0] a, output [31:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      reg_priv <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task xl(input [31:0] a, input w, input p);
      u_tat_core_model.issue(a, w, p);
      #1;
   endtask

   task load;
      @(posedge clk);
      load_entry_op <= 1'b1;
      @(posedge clk);
      load_entry_op <= 1'b0;
   endtask

   // Model of the rights table: 0 go, 1 protection, 2 first write
   function automatic int fault(input [1:0] rights, input p, input w, input dt);
      if (!(rights == `TAT_RIGHTS_ALL_RW || (!w && (p || rights[1])) || (w && p && rights == `TAT_RIGHTS_PRIV_RW)))
         return 1;
      return (w && !dt) ? 2 : 0;
   endfunction

   initial
   begin
      repeat (50000) @(posedge clk);
      fails++;
      print_verdict;
   end

   initial
   begin
      void'($urandom(79));
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 5; i++)
      begin
         rd(rmap[i], r);
         check("reset value", r, 32'h0);
      end
      d = $urandom;
      wr(`TAT_ADDR_BASE, d, 1'b1);
      wr(`TAT_ADDR_BASE, ~d, 1'b0);
      #1 check("refused", reg_refused, 32'h1);
      rd(`TAT_ADDR_BASE, r);
      check("table base", r, d);
      rd(32'h0FFFFFE8, r);
      check("unmapped", r, 32'h0);
      for (int i = 0; i < 16; i++)
      begin
         va = $urandom & 32'h7FFFFFFF;
         id = $urandom;
         frame = $urandom;
         {big, shared, hash} = $urandom;
         // Flush each round so no two ways can match one page
         wr(`TAT_ADDR_CTRL, {26'h0, hash, 5'h05}, 1'b1);
         wr(`TAT_ADDR_PEH, {va[31:10], 2'h0, id}, 1'b1);
         xl(va, 1'b0, 1'b1);
         check("miss", exc_miss, 32'h1);
         rd(`TAT_ADDR_FAULT, r);
         check("fault address", r, va);
         rd(`TAT_ADDR_PEH, r);
         check("fault page", r, {va[31:10], 2'h0, id});
         rd(`TAT_ADDR_CTRL, r);
         check("control", r, {26'h0, hash, 5'h01});
         pel = {3'h0, frame, 3'h2, i[1:0], big, i[3], i[2], shared, 1'b0};
         wr(`TAT_ADDR_PEL, pel, 1'b1);
         load;
         pa = big ? {3'h0, frame[18:2], va[11:0]} : {3'h0, frame, va[9:0]};
         for (int k = 0; k < 4; k++)
         begin
            xl(va, k[0], k[1]);
            f = fault(i[1:0], k[1], k[0], i[2]);
            check("protect", exc_prot, f == 1);
            check("first write", exc_init_write, f == 2);
            check("go", resp_go, f == 0);
            check("valid", resp_valid, 32'h1);
            if (f == 0)
            begin
               check("paddr", resp_paddr, pa);
               check("cacheable", resp_cacheable, i[3]);
            end
         end
         rd(`TAT_ADDR_PEL, r);
         check("low word", r, pel);
         xl(va ^ 32'h400, 1'b0, 1'b1);
         check("size compare", exc_miss, !big);
         // A small-page miss finds only way 0 valid, so the lowest free way is 1
         rd(`TAT_ADDR_CTRL, r);
         check("free way", r, {24'h0, 1'b0, !big, hash, 5'h01});
         wr(`TAT_ADDR_PEH, {va[31:10], 2'h0, id ^ 8'h01}, 1'b1);
         xl(va, 1'b0, 1'b1);
         check("id compare", exc_miss, hash | !shared);
         wr(`TAT_ADDR_CTRL, {23'h0, 1'b1, 2'h0, hash, 5'h01}, 1'b1);
         xl(va, 1'b0, 1'b1);
         check("single space", exc_miss, hash);
      end
      xl(32'h80001234, 1'b0, 1'b0);
      check("address error", exc_addr_err, 32'h1);
      rd(`TAT_ADDR_FAULT, r);
      check("error address", r, 32'h80001234);
      // Fixed regions bypass the buffer; only the fixed region starting at 80000000 is cached
      xl(32'hA0005678, 1'b1, 1'b1);
      check("fixed paddr", resp_paddr, 32'h00005678);
      check("fixed uncached", resp_cacheable, 32'h0);
      xl(32'h80005678, 1'b0, 1'b1);
      check("fixed go", resp_go, 32'h1);
      check("fixed cached", resp_cacheable, 32'h1);
      print_verdict;
   end
endmodule
